// ---- hw/srf_spi_regfile.sv ----
`timescale 1ns/100ps
`include "srf_regs.svh"
// Notes on behaviour
// - Byte registers at addresses 0 to 15; 6, 7, 14 and 15 unmapped
// - Addresses 0-3 give accelerometer word
// - Addresses 4-5 give temperature, 14 bits
// - Addresses 8-11 are indirect data buffer
// - Address 12 holds indirect target address
// - Writing address 13 triggers indirect transfer
// - Frame: command nibble, address nibble, argument bytes
// - Command 5 reads, address increments per byte
// - Command 7 writes bytes from given address
// - Fresh flag set on sample, cleared when read
// - Fresh flag first bit, then 24-bit value
// - Command byte 1 fetches, 2 stores
// - Fetch copies system word into slots 8-11
// - Store copies slots 8-11 into system word
// - Select low frames; shift falling, sample rising
// - System array: 8-bit address, 32-bit entries
module srf_spi_regfile
   import srf_pkg::*;
#(
   parameter int SYS_ENTRIES = `SRF_SYS_ENTRIES
) (
   input  wire logic        CLK,
   input  wire logic        RESET,
   input  wire logic        SCK,
   input  wire logic        SSN,
   input  wire logic        MOSI,
   output logic             MISO,
   output logic             MISO_OE,
   input  wire logic [23:0] ACC_VALUE,
   input  wire logic        ACC_LOAD,
   input  wire logic [13:0] TEMP_VALUE,
   input  wire logic        TEMP_LOAD
);

   // Array index is eight bits wide, so more than 256 entries cannot be reached
   if (SYS_ENTRIES < 1 || SYS_ENTRIES > 256) begin : g_bad_entries
      $error("SYS_ENTRIES out of range");
   end

   // Link domain: frame position, cleared by the select between frames
   typedef struct packed {
      logic [2:0] bitcnt;
      logic [6:0] shin;
      logic       first;
   } srf_frm_t;

   // Link domain: captured fields that must survive the select going high
   typedef struct packed {
      logic [3:0] cmd;
      logic [3:0] addr;
      logic [7:0] rx_byte;
      logic       rx_tgl;
      logic       rx_first;
      logic [3:0] rx_addr;
      logic [3:0] rx_cmd;
   } srf_lnk_t;

   srf_frm_t   frm_q, frm_d;
   srf_lnk_t   lnk_q, lnk_d;
   logic [7:0] shout_q;
   logic       start_tgl_q;
   logic [7:0] rd_data;

   // Bit counter restarts on select high; clocked only while framed
   always_comb begin
      frm_d = frm_q;
      lnk_d = lnk_q;
      frm_d.shin   = {frm_q.shin[5:0], MOSI};
      frm_d.bitcnt = frm_q.bitcnt + 3'h1;
      if (frm_q.bitcnt == 3'h7) begin
         lnk_d.rx_byte  = {frm_q.shin, MOSI};
         lnk_d.rx_tgl   = ~lnk_q.rx_tgl;
         lnk_d.rx_first = frm_q.first;
         if (frm_q.first) begin
            lnk_d.cmd     = frm_q.shin[6:3];
            lnk_d.addr    = {frm_q.shin[2:0], MOSI};
            frm_d.first   = 1'b0;
            lnk_d.rx_addr = {frm_q.shin[2:0], MOSI};
            lnk_d.rx_cmd  = frm_q.shin[6:3];
         end else begin
            lnk_d.rx_addr = lnk_q.addr;
            lnk_d.rx_cmd  = lnk_q.cmd;
            lnk_d.addr    = lnk_q.addr + 4'h1;
         end
      end
   end

   // Async clear by select keeps the frame start clean without a free-running SCK
   always_ff @(posedge SCK or posedge SSN) begin
      if (SSN) begin
         frm_q <= {3'h0, 7'h00, 1'b1};
      end else begin
         frm_q <= frm_d;
      end
   end

   // Core reset also clears the toggle, so the core never sees an unknown edge.
   // SCK is idle while reset is held, so its release cannot race a shift.
   always_ff @(posedge SCK or posedge RESET) begin
      if (RESET) begin
         lnk_q <= '0;
      end else begin
         lnk_q <= lnk_d;
      end
   end

   // Outgoing byte loaded at falling edge after each byte boundary of a read frame.
   // The read byte is sampled from the core file, which is stable between
   // host bytes; a multi-bit read across domains is tolerated here because
   // the addressed slot only changes on sample loads, a known trade-off.
   always_ff @(negedge SCK or posedge SSN) begin
      if (SSN) begin
         shout_q <= 8'h00;
      end else if (frm_q.bitcnt == 3'h0 && !frm_q.first && lnk_q.cmd == `SRF_CMD_READ) begin
         shout_q <= rd_data;
      end else begin
         shout_q <= {shout_q[6:0], 1'b0};
      end
   end
   // Output bit and its enable
   assign MISO        = shout_q[7];
   assign MISO_OE     = ~SSN;
   assign start_tgl_q = lnk_q.rx_tgl;

   // Core domain state
   typedef struct packed {
      logic [2:0]  sync;
      logic [31:0] acc;
      logic [15:0] temp;
      logic [31:0] buf_w;
      logic [7:0]  target;
      logic [7:0]  command;
      logic [3:0]  rd_addr;
      logic        fetch_go;
      logic        store_go;
      srf_mode_t   mode;
   } srf_core_t;

   srf_core_t  core_q, core_d;
   logic [31:0] sys_mem [SYS_ENTRIES];
   logic [31:0] sys_rd;
   logic        rx_evt;
   logic [7:0]  wr_idx;

   assign rx_evt = core_q.sync[2] ^ core_q.sync[1];
   assign wr_idx = core_q.target;

   // Register file read decode; unmapped slots read zero
   always_comb begin
      rd_data = 8'h00;
      case (lnk_q.addr)
         4'h0: rd_data = core_q.acc[31:24];
         4'h1: rd_data = core_q.acc[23:16];
         4'h2: rd_data = core_q.acc[15:8];
         4'h3: rd_data = core_q.acc[7:0];
         `SRF_ADDR_TEMPH: rd_data = core_q.temp[15:8];
         `SRF_ADDR_TEMPL: rd_data = core_q.temp[7:0];
         `SRF_ADDR_DATA0: rd_data = core_q.buf_w[31:24];
         `SRF_ADDR_DATA1: rd_data = core_q.buf_w[23:16];
         `SRF_ADDR_DATA2: rd_data = core_q.buf_w[15:8];
         `SRF_ADDR_DATA3: rd_data = core_q.buf_w[7:0];
         `SRF_ADDR_TARGET: rd_data = core_q.target;
         default: rd_data = 8'h00;
      endcase
   end

   assign sys_rd = sys_mem[wr_idx];

   // Byte handling, indirect commands and sample capture
   always_comb begin
      core_d = core_q;
      core_d.sync     = {core_q.sync[1:0], start_tgl_q};
      core_d.fetch_go = 1'b0;
      core_d.store_go = 1'b0;
      if (ACC_LOAD) begin
         core_d.acc = {1'b1, ACC_VALUE, 7'h00};
      end
      if (TEMP_LOAD) begin
         core_d.temp = {2'b00, TEMP_VALUE};
      end
      if (rx_evt && !lnk_q.rx_first) begin
         case (lnk_q.rx_cmd)
            `SRF_CMD_READ: begin
               core_d.mode = SRF_READ;
               // Reading the flag byte clears it unless a new sample lands now
               if (lnk_q.rx_addr == `SRF_ADDR_ACC0 && !ACC_LOAD) begin
                  core_d.acc[`SRF_FRESH_BIT] = 1'b0;
               end
            end
            `SRF_CMD_WRITE: begin
               core_d.mode = SRF_WRITE;
               case (lnk_q.rx_addr)
                  `SRF_ADDR_DATA0: core_d.buf_w[31:24] = lnk_q.rx_byte;
                  `SRF_ADDR_DATA1: core_d.buf_w[23:16] = lnk_q.rx_byte;
                  `SRF_ADDR_DATA2: core_d.buf_w[15:8]  = lnk_q.rx_byte;
                  `SRF_ADDR_DATA3: core_d.buf_w[7:0]   = lnk_q.rx_byte;
                  `SRF_ADDR_TARGET: core_d.target      = lnk_q.rx_byte;
                  `SRF_ADDR_COMMAND: begin
                     core_d.command  = lnk_q.rx_byte;
                     core_d.fetch_go = (lnk_q.rx_byte == `SRF_SYS_FETCH);
                     core_d.store_go = (lnk_q.rx_byte == `SRF_SYS_STORE);
                  end
                  default: core_d.command = core_q.command;
               endcase
            end
            default: core_d.mode = SRF_IDLE;
         endcase
      end
      if (core_q.fetch_go) begin
         core_d.buf_w = sys_rd;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         core_q <= '0;
      end else begin
         core_q <= core_d;
      end
   end

   // System array write port; entries out of range are ignored
   always_ff @(posedge CLK) begin
      if (core_q.store_go && int'(wr_idx) < SYS_ENTRIES) begin
         sys_mem[wr_idx] <= core_q.buf_w;
      end
   end

   // Qualified byte events seen by the core, one per host byte after the first
   logic rd_evt, wr_evt;
   assign rd_evt = rx_evt && !lnk_q.rx_first && lnk_q.rx_cmd == `SRF_CMD_READ;
   assign wr_evt = rx_evt && !lnk_q.rx_first && lnk_q.rx_cmd == `SRF_CMD_WRITE;

   // Checks on sample capture, indirect command pulses and the output enable
   property p_fresh_set;
      @(posedge CLK) disable iff (RESET) ACC_LOAD |=> core_q.acc[`SRF_FRESH_BIT];
   endproperty
   a_fresh_set: assert property (p_fresh_set) else $error("fresh flag not set");

   property p_acc_value;
      @(posedge CLK) disable iff (RESET)
         ACC_LOAD |=> core_q.acc[30:7] == $past(ACC_VALUE);
   endproperty
   a_acc_value: assert property (p_acc_value) else $error("accel value misplaced");

   property p_temp;
      @(posedge CLK) disable iff (RESET) TEMP_LOAD |=> core_q.temp[13:0] == $past(TEMP_VALUE);
   endproperty
   a_temp: assert property (p_temp) else $error("temperature not captured");

   property p_fetch;
      @(posedge CLK) disable iff (RESET) core_q.fetch_go |=> core_q.buf_w == $past(sys_rd);
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch did not fill buffer");

   property p_store_pulse;
      @(posedge CLK) disable iff (RESET) core_q.store_go |=> !core_q.store_go;
   endproperty
   a_store_pulse: assert property (p_store_pulse) else $error("store repeated");

   property p_cmd_decode;
      @(posedge CLK) disable iff (RESET)
         core_q.fetch_go |-> core_q.command == `SRF_SYS_FETCH;
   endproperty
   a_cmd_decode: assert property (p_cmd_decode) else $error("fetch without command");

   property p_store_decode;
      @(posedge CLK) disable iff (RESET)
         core_q.store_go |-> core_q.command == `SRF_SYS_STORE;
   endproperty
   a_store_decode: assert property (p_store_decode) else $error("store without command");

   property p_oe;
      @(posedge CLK) disable iff (RESET) SSN |-> !MISO_OE;
   endproperty
   a_oe: assert property (p_oe) else $error("output driven while deselected");

   // Reading the flag byte clears the flag
   property p_fresh_clear;
      @(posedge CLK) disable iff (RESET)
         rd_evt && lnk_q.rx_addr == `SRF_ADDR_ACC0 && !ACC_LOAD |=> !core_q.acc[`SRF_FRESH_BIT];
   endproperty
   a_fresh_clear: assert property (p_fresh_clear) else $error("fresh flag not cleared");

   // The flag only moves on a load or a read of byte zero
   property p_fresh_hold;
      @(posedge CLK) disable iff (RESET)
         !ACC_LOAD && !(rd_evt && lnk_q.rx_addr == `SRF_ADDR_ACC0)
         |=> core_q.acc[`SRF_FRESH_BIT] == $past(core_q.acc[`SRF_FRESH_BIT]);
   endproperty
   a_fresh_hold: assert property (p_fresh_hold) else $error("fresh flag moved");

   // Host writes to the sensor slots leave the sensor values unchanged
   property p_sensor_ro;
      @(posedge CLK) disable iff (RESET)
         wr_evt && lnk_q.rx_addr <= `SRF_ADDR_TEMPL && !ACC_LOAD && !TEMP_LOAD
         |=> core_q.acc == $past(core_q.acc) && core_q.temp == $past(core_q.temp);
   endproperty
   a_sensor_ro: assert property (p_sensor_ro) else $error("sensor slot written");

   // Slot 8 carries the top byte of the buffer
   property p_buf_top;
      @(posedge CLK) disable iff (RESET)
         wr_evt && lnk_q.rx_addr == `SRF_ADDR_DATA0 && !core_q.fetch_go
         |=> core_q.buf_w[31:24] == $past(lnk_q.rx_byte);
   endproperty
   a_buf_top: assert property (p_buf_top) else $error("slot 8 misplaced");

   // Slot 11 carries the bottom byte of the buffer
   property p_buf_bottom;
      @(posedge CLK) disable iff (RESET)
         wr_evt && lnk_q.rx_addr == `SRF_ADDR_DATA3 && !core_q.fetch_go
         |=> core_q.buf_w[7:0] == $past(lnk_q.rx_byte);
   endproperty
   a_buf_bottom: assert property (p_buf_bottom) else $error("slot 11 misplaced");

   // Target address lands from its slot
   property p_target_wr;
      @(posedge CLK) disable iff (RESET)
         wr_evt && lnk_q.rx_addr == `SRF_ADDR_TARGET |=> core_q.target == $past(lnk_q.rx_byte);
   endproperty
   a_target_wr: assert property (p_target_wr) else $error("target not written");

   // A fetch byte in slot 13 starts a fetch
   property p_fetch_trigger;
      @(posedge CLK) disable iff (RESET)
         wr_evt && lnk_q.rx_addr == `SRF_ADDR_COMMAND && lnk_q.rx_byte == `SRF_SYS_FETCH
         |=> core_q.fetch_go;
   endproperty
   a_fetch_trigger: assert property (p_fetch_trigger) else $error("fetch not started");

   // A store byte in slot 13 starts a store
   property p_store_trigger;
      @(posedge CLK) disable iff (RESET)
         wr_evt && lnk_q.rx_addr == `SRF_ADDR_COMMAND && lnk_q.rx_byte == `SRF_SYS_STORE
         |=> core_q.store_go;
   endproperty
   a_store_trigger: assert property (p_store_trigger) else $error("store not started");

   // A store reaches the array entry named by the target
   property p_store_lands;
      @(posedge CLK) disable iff (RESET)
         core_q.store_go && int'(wr_idx) < SYS_ENTRIES |=> sys_rd == $past(core_q.buf_w);
   endproperty
   a_store_lands: assert property (p_store_lands) else $error("store did not land");

   // A fetch is a single pulse
   property p_fetch_pulse;
      @(posedge CLK) disable iff (RESET) core_q.fetch_go |=> !core_q.fetch_go;
   endproperty
   a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch repeated");

   // The synchroniser gives one event per byte
   property p_evt_single;
      @(posedge CLK) disable iff (RESET) rx_evt |=> !rx_evt;
   endproperty
   a_evt_single: assert property (p_evt_single) else $error("byte event repeated");

   // Temperature padding bits stay zero
   property p_temp_pad;
      @(posedge CLK) disable iff (RESET) TEMP_LOAD |=> core_q.temp[15:14] == 2'b00;
   endproperty
   a_temp_pad: assert property (p_temp_pad) else $error("temperature padding set");

   // Read bytes put the core in read mode
   property p_mode_read;
      @(posedge CLK) disable iff (RESET) rd_evt |=> core_q.mode == SRF_READ;
   endproperty
   a_mode_read: assert property (p_mode_read) else $error("read mode not taken");

   // Write bytes put the core in write mode
   property p_mode_write;
      @(posedge CLK) disable iff (RESET) wr_evt |=> core_q.mode == SRF_WRITE;
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("write mode not taken");

   c_fetch: cover property (@(posedge CLK) disable iff (RESET) core_q.fetch_go);
   c_store: cover property (@(posedge CLK) disable iff (RESET) core_q.store_go);
   c_read:  cover property (@(posedge CLK) disable iff (RESET) core_q.mode == SRF_READ);
   c_write: cover property (@(posedge CLK) disable iff (RESET) wr_evt);
   c_clear: cover property (@(posedge CLK) disable iff (RESET)
      rd_evt && lnk_q.rx_addr == `SRF_ADDR_ACC0);

endmodule // srf_spi_regfile

// ---- shared/srf_regs.svh ----
`ifndef SRF_REGS_SVH
`define SRF_REGS_SVH
`define SRF_CMD_READ      4'h5
`define SRF_CMD_WRITE     4'h7
`define SRF_ADDR_ACC0     4'h0
`define SRF_ADDR_ACC3     4'h3
`define SRF_ADDR_TEMPH    4'h4
`define SRF_ADDR_TEMPL    4'h5
`define SRF_ADDR_DATA0    4'h8
`define SRF_ADDR_DATA1    4'h9
`define SRF_ADDR_DATA2    4'ha
`define SRF_ADDR_DATA3    4'hb
`define SRF_ADDR_TARGET   4'hc
`define SRF_ADDR_COMMAND  4'hd
`define SRF_SYS_FETCH     8'h01
`define SRF_SYS_STORE     8'h02
`define SRF_FRESH_BIT     31
`define SRF_SYS_ENTRIES   256
`endif

// ---- shared/srf_pkg.sv ----
package srf_pkg;
   typedef enum logic [1:0] {SRF_IDLE, SRF_READ, SRF_WRITE} srf_mode_t;
endpackage

// ---- verif/srf_spi_master.sv ----
`timescale 1ns/100ps
// Host side of the serial link: mode 0, link clock runs only inside frames
module srf_spi_master (
   output logic      SCK,
   output logic      SSN,
   output logic      MOSI,
   input  wire logic MISO,
   input  wire logic MISO_OE
);
   localparam int HALF = 32; // 64 ns link period
   // Idle levels
   initial begin
      SCK = 1'b0;
      SSN = 1'b0;
      MOSI = 1'b0;
      // Clean rising select so the slave's frame logic starts cleared
      #1 SSN = 1'b1;
   end
   // Odd offset keeps the link unrelated in phase to the core clock
   task start();
      #7 SSN = 1'b0;
      #(2*HALF);
   endtask
   // Released data line flips so stale bits are never mistaken for data
   task stop();
      #(2*HALF) SSN = 1'b1;
      MOSI = ~MOSI;
   endtask
   // One byte MSB first; change after fall, sample on rise
   task xb(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         MOSI = tx[i];
         #HALF SCK = 1'b1;
         rx[i] = MISO_OE ? MISO : 1'bx;
         #HALF SCK = 1'b0;
      end
   endtask
endmodule // srf_spi_master

// ---- verif/srf_spi_regfile_tb.sv ----
`timescale 1ns/100ps
`include "srf_regs.svh"
module srf_spi_regfile_tb
   import srf_pkg::*;
;
   logic        CLK, RESET, ACC_LOAD, TEMP_LOAD;
   logic [23:0] ACC_VALUE;
   logic [13:0] TEMP_VALUE;
   logic        SCK, SSN, MOSI, MISO, MISO_OE;
   logic [31:0] w;
   int          err_count, n_tests, cyc;
   // Core clock 100 ns
   always #50 CLK = ~CLK;
   srf_spi_regfile DUT (.CLK(CLK), .RESET(RESET), .SCK(SCK), .SSN(SSN), .MOSI(MOSI),
      .MISO(MISO), .MISO_OE(MISO_OE), .ACC_VALUE(ACC_VALUE), .ACC_LOAD(ACC_LOAD),
      .TEMP_VALUE(TEMP_VALUE), .TEMP_LOAD(TEMP_LOAD));
   srf_spi_master m (.SCK(SCK), .SSN(SSN), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE));
   task end_sim();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Write frame; wait lets a triggered indirect transfer finish
   task wr(input logic [3:0] a, input logic [7:0] q[$]);
      logic [7:0] r;
      m.start();
      m.xb({`SRF_CMD_WRITE, a}, r);
      foreach (q[k]) m.xb(q[k], r);
      m.stop();
      repeat (8) @(posedge CLK);
   endtask
   task rd(input logic [3:0] a, input int n, output logic [31:0] v);
      logic [7:0] r;
      v = '0;
      m.start();
      m.xb({`SRF_CMD_READ, a}, r);
      repeat (n) begin
         m.xb(8'h00, r);
         v = {v[23:0], r};
      end
      m.stop();
      repeat (4) @(posedge CLK);
   endtask
   // Hang guard
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end
   // Main sequence
   initial begin
      CLK = 1'b0;
      RESET = 1'b0;
      #1 RESET = 1'b1;
      ACC_LOAD = 1'b0;
      TEMP_LOAD = 1'b0;
      ACC_VALUE = 24'h000000;
      TEMP_VALUE = 14'h0000;
      repeat (16) @(posedge CLK);
      #1 RESET = 1'b0;
      repeat (4) @(posedge CLK);
      #1 ACC_VALUE = 24'h876543;
      ACC_LOAD = 1'b1;
      TEMP_VALUE = 14'h2abc;
      TEMP_LOAD = 1'b1;
      @(posedge CLK);
      #1 ACC_LOAD = 1'b0;
      TEMP_LOAD = 1'b0;
      repeat (4) @(posedge CLK);
      rd(`SRF_ADDR_ACC0, 4, w);
      chk("acc word", {1'b1, 24'h876543, 7'h00}, w);
      rd(`SRF_ADDR_ACC0, 4, w);
      chk("acc reread", {1'b0, 24'h876543, 7'h00}, w);
      wr(`SRF_ADDR_ACC0, '{8'hff});
      rd(`SRF_ADDR_ACC0, 1, w);
      chk("acc read only", 32'h00000043, w);
      rd(`SRF_ADDR_TEMPH, 2, w);
      chk("temp", {18'h00000, 14'h2abc}, w);
      $display("test sensors done");
      wr(`SRF_ADDR_DATA0, '{8'hde, 8'had, 8'hbe, 8'hef, 8'hff, `SRF_SYS_STORE});
      wr(`SRF_ADDR_DATA0, '{8'h12, 8'h34, 8'h56, 8'h78, 8'h3c, `SRF_SYS_STORE});
      wr(`SRF_ADDR_DATA0, '{8'h00, 8'h00, 8'h00, 8'h00});
      wr(`SRF_ADDR_TARGET, '{8'hff, 8'h03});
      rd(`SRF_ADDR_TARGET, 1, w);
      chk("target", 32'h000000ff, w);
      rd(`SRF_ADDR_DATA0, 4, w);
      chk("buffer kept", 32'h00000000, w);
      wr(`SRF_ADDR_TARGET, '{8'hff, `SRF_SYS_FETCH});
      rd(`SRF_ADDR_DATA0, 4, w);
      chk("fetch ff", 32'hdeadbeef, w);
      wr(`SRF_ADDR_TARGET, '{8'h3c, `SRF_SYS_FETCH});
      rd(`SRF_ADDR_DATA0, 4, w);
      chk("fetch 3c", 32'h12345678, w);
      $display("test indirect done");
      end_sim();
   end
endmodule // srf_spi_regfile_tb
